// [vov_defs.svh]
`ifndef VOV_DEFS_SVH
`define VOV_DEFS_SVH
// Function
// - setpoint reads zero in bits 15:12, writable 12-bit mantissa below.
// - setpoint mantissa is Y in Y times two to the output exponent.
// - loop scale: writable 5-bit exponent, bit 10 zero, writable 10-bit mantissa.
// - monitor scale: 3-bit exponent, 10-bit mantissa, bit 10 zero, top bits reserved.
// - conversion starts once measured input reaches the start threshold.
// - conversion stops when measured input falls to the stop threshold.
// - input threshold exponents are read-only mirrors of the input exponent field.
// - input thresholds hold a writable 11-bit mantissa, high part plus low byte.
// - output overvoltage fault when measured output exceeds the limit.
// - limit exponent is read-only, returns the output exponent of the mode register.
// - overvoltage limit holds a writable 11-bit mantissa.
// - response code 00 takes no action on an overvoltage fault.
// - code 01 keeps running for delay one, then retries if fault persists.
// - code 10 shuts down at once, then retries per the retry field.
// - code 11 disables output, waits for the fault to clear, re-enables.
// - retry codes 0 to 6 give that many retries, 7 unlimited; delay two between.
// - retries used up with fault present keep the output off until reset.
// - delay field picks delay one: 10, 20 or 40 ms.
// - output exponent is a writable 3-bit field shared by all output values.

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define VOV_CMD_VOUT_MODE    8'h20
`define VOV_CMD_SETPOINT     8'h21
`define VOV_CMD_LOOP_SCALE   8'h29
`define VOV_CMD_MON_SCALE    8'h2a
`define VOV_CMD_VIN_START    8'h35
`define VOV_CMD_VIN_STOP     8'h36
`define VOV_CMD_OV_LIMIT     8'h40
`define VOV_CMD_OV_ACTION    8'h41

// ----------------------------------------------------------------------
// writable bit masks and field positions
// ----------------------------------------------------------------------
`define VOV_WMASK_SETPOINT   16'h0fff
`define VOV_WMASK_LOOP       16'hfbff
`define VOV_WMASK_MON        16'h3bff
`define VOV_WMASK_MANT11     16'h07ff
`define VOV_WMASK_ACTION     16'h00ff
`define VOV_WMASK_MODE       16'h0007
`define VOV_EXP_LSB          11
`define VOV_RESP_LSB         6
`define VOV_RETRY_LSB        3
`define VOV_RETRY_INF        3'h7

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define VOV_RST_WORD         16'h0000
`define VOV_RST_ACTION       8'h00
`define VOV_CLK_MHZ          200
`define VOV_CYC_PER_MS       (`VOV_CLK_MHZ * 1000)
`define VOV_DLY1_0_MS        10
`define VOV_DLY1_1_MS        20
`define VOV_DLY1_2_MS        40
`define VOV_DLY2_0_MS        252
`define VOV_DLY2_1_MS        558
`define VOV_DLY2_2_MS        924
`define VOV_TMR_W            28
`endif

// [vov_pkg.sv]
`include "vov_defs.svh"
package vov_pkg;
   typedef logic [`VOV_TMR_W-1:0] vov_tmr_t;
   typedef enum logic [1:0] {
      VOV_RESP_NONE, VOV_RESP_DELAY, VOV_RESP_SHUT, VOV_RESP_HOLD
   } vov_resp_t;
   typedef enum logic [2:0] {
      VOV_OVS_RUN, VOV_OVS_DLY1, VOV_OVS_OFF, VOV_OVS_PROBE, VOV_OVS_HOLD, VOV_OVS_LATCH
   } vov_ovs_t;
endpackage : vov_pkg

// [vov_tmr_if.sv]
interface vov_tmr_if;
   import vov_pkg::*;
   // load starts a countdown, done pulses when it runs out
   logic     load;
   vov_tmr_t load_val;
   logic     done;
   modport ctl (output load, output load_val, input done);
   modport tmr (input load, input load_val, output done);
endinterface : vov_tmr_if

// [vov_timer.sv]
module vov_timer (
   input wire logic sys_clk,
   input wire logic resetn,
   vov_tmr_if.tmr   tb
);
   import vov_pkg::*;

   vov_tmr_t cnt_ff;
   vov_tmr_t nxt_cnt;

   // countdown, reload wins over running
   always_comb begin
      if (tb.load) begin
         nxt_cnt = tb.load_val;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - vov_tmr_t'(1);
      end else begin
         nxt_cnt = cnt_ff;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // expiry depends on the count only: the sequencer loads on done, so
   // gating done with load would close a combinational loop
   assign tb.done = (cnt_ff == vov_tmr_t'(1));
endmodule : vov_timer

// [vov_regs.sv]
`include "vov_defs.svh"
module vov_regs #(
   parameter vov_pkg::vov_tmr_t DLY1_0_CYC = vov_pkg::vov_tmr_t'(`VOV_DLY1_0_MS * `VOV_CYC_PER_MS),
   parameter vov_pkg::vov_tmr_t DLY1_1_CYC = vov_pkg::vov_tmr_t'(`VOV_DLY1_1_MS * `VOV_CYC_PER_MS),
   parameter vov_pkg::vov_tmr_t DLY1_2_CYC = vov_pkg::vov_tmr_t'(`VOV_DLY1_2_MS * `VOV_CYC_PER_MS),
   parameter vov_pkg::vov_tmr_t DLY2_0_CYC = vov_pkg::vov_tmr_t'(`VOV_DLY2_0_MS * `VOV_CYC_PER_MS),
   parameter vov_pkg::vov_tmr_t DLY2_1_CYC = vov_pkg::vov_tmr_t'(`VOV_DLY2_1_MS * `VOV_CYC_PER_MS),
   parameter vov_pkg::vov_tmr_t DLY2_2_CYC = vov_pkg::vov_tmr_t'(`VOV_DLY2_2_MS * `VOV_CYC_PER_MS)
) (
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic [7:0]   reg_cmd,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   input  wire logic [15:0]  reg_wdata,
   output logic      [15:0]  reg_rdata,
   output logic              reg_rvalid,
   input  wire logic [2:0]   vin_exp_field,
   input  wire logic [10:0]  vin_meas,
   input  wire logic [10:0]  vout_meas,
   output logic      [11:0]  vout_target_mant,
   output logic      [2:0]   vout_exp,
   output logic      [15:0]  loop_scale,
   output logic      [15:0]  monitor_scale_factor,
   output logic              conv_run,
   output logic              output_en,
   output logic              ov_fault,
   output logic              ov_latched,
   output vov_pkg::vov_ovs_t ov_state
);
   import vov_pkg::*;

   // ----------------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------------
   logic [15:0] setpt_ff, nxt_setpt;
   logic [15:0] loop_ff, nxt_loop;
   logic [15:0] mon_ff, nxt_mon;
   logic [15:0] start_ff, nxt_start;
   logic [15:0] stop_ff, nxt_stop;
   logic [15:0] ovlim_ff, nxt_ovlim;
   logic [7:0]  act_ff, nxt_act;
   logic [2:0]  mode_exp_ff, nxt_mode_exp;

   // widen a 3-bit two's complement exponent to the 5-bit field
   function automatic logic [4:0] sext3(input logic [2:0] e);
      return {{2{e[2]}}, e};
   endfunction : sext3

   // only writable bits are stored, so read-only bits can never latch
   // stray host data; mirrors are built at read time instead
   always_comb begin
      nxt_setpt    = setpt_ff;
      nxt_loop     = loop_ff;
      nxt_mon      = mon_ff;
      nxt_start    = start_ff;
      nxt_stop     = stop_ff;
      nxt_ovlim    = ovlim_ff;
      nxt_act      = act_ff;
      nxt_mode_exp = mode_exp_ff;
      if (reg_wr) begin
         case (reg_cmd)
            `VOV_CMD_VOUT_MODE:  nxt_mode_exp = reg_wdata[2:0];
            `VOV_CMD_SETPOINT:   nxt_setpt = reg_wdata & `VOV_WMASK_SETPOINT;
            `VOV_CMD_LOOP_SCALE: nxt_loop  = reg_wdata & `VOV_WMASK_LOOP;
            `VOV_CMD_MON_SCALE:  nxt_mon   = reg_wdata & `VOV_WMASK_MON;
            `VOV_CMD_VIN_START:  nxt_start = reg_wdata & `VOV_WMASK_MANT11;
            `VOV_CMD_VIN_STOP:   nxt_stop  = reg_wdata & `VOV_WMASK_MANT11;
            `VOV_CMD_OV_LIMIT:   nxt_ovlim = reg_wdata & `VOV_WMASK_MANT11;
            `VOV_CMD_OV_ACTION:  nxt_act   = reg_wdata[7:0];
            default: begin
               // unmapped codes are dropped
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         setpt_ff    <= `VOV_RST_WORD;
         loop_ff     <= `VOV_RST_WORD;
         mon_ff      <= `VOV_RST_WORD;
         start_ff    <= `VOV_RST_WORD;
         stop_ff     <= `VOV_RST_WORD;
         ovlim_ff    <= `VOV_RST_WORD;
         act_ff      <= `VOV_RST_ACTION;
         mode_exp_ff <= 3'h0;
      end else begin
         setpt_ff    <= nxt_setpt;
         loop_ff     <= nxt_loop;
         mon_ff      <= nxt_mon;
         start_ff    <= nxt_start;
         stop_ff     <= nxt_stop;
         ovlim_ff    <= nxt_ovlim;
         act_ff      <= nxt_act;
         mode_exp_ff <= nxt_mode_exp;
      end
   end

   // ----------------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------------
   logic [15:0] rdata_ff, nxt_rdata;
   logic        rvalid_ff;

   // data is held between reads so the host may sample it late
   always_comb begin
      nxt_rdata = rdata_ff;
      if (reg_rd) begin
         case (reg_cmd)
            `VOV_CMD_VOUT_MODE:  nxt_rdata = {13'h0000, mode_exp_ff};
            `VOV_CMD_SETPOINT:   nxt_rdata = setpt_ff;
            `VOV_CMD_LOOP_SCALE: nxt_rdata = loop_ff;
            `VOV_CMD_MON_SCALE:  nxt_rdata = mon_ff;
            `VOV_CMD_VIN_START:  nxt_rdata = {sext3(vin_exp_field), start_ff[10:0]};
            `VOV_CMD_VIN_STOP:   nxt_rdata = {sext3(vin_exp_field), stop_ff[10:0]};
            `VOV_CMD_OV_LIMIT:   nxt_rdata = {sext3(mode_exp_ff), ovlim_ff[10:0]};
            `VOV_CMD_OV_ACTION:  nxt_rdata = {8'h00, act_ff};
            default:             nxt_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff  <= 16'h0000;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= reg_rd;
      end
   end

   assign reg_rdata  = rdata_ff;
   assign reg_rvalid = rvalid_ff;

   // setpoint and scale factors feed the loop as stored
   assign vout_target_mant     = setpt_ff[11:0];
   assign vout_exp             = mode_exp_ff;
   assign loop_scale           = loop_ff;
   assign monitor_scale_factor = mon_ff;

   // ----------------------------------------------------------------------
   // input thresholds and overvoltage compare
   // ----------------------------------------------------------------------
   logic run_ff, nxt_run;
   logic ov_det_ff, nxt_ov_det;

   // measurements share the exponents of the thresholds, so mantissas
   // compare directly; the gap between start and stop gives hysteresis
   always_comb begin
      nxt_run = run_ff;
      if (!run_ff && (vin_meas >= start_ff[10:0])) begin
         nxt_run = 1'b1;
      end else if (run_ff && (vin_meas <= stop_ff[10:0])) begin
         nxt_run = 1'b0;
      end
      nxt_ov_det = (vout_meas > ovlim_ff[10:0]);
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         run_ff    <= 1'b0;
         ov_det_ff <= 1'b0;
      end else begin
         run_ff    <= nxt_run;
         ov_det_ff <= nxt_ov_det;
      end
   end

   assign conv_run = run_ff;
   assign ov_fault = ov_det_ff;

   // ----------------------------------------------------------------------
   // overvoltage response sequencer
   // ----------------------------------------------------------------------
   vov_tmr_if tmr_bus ();

   vov_timer u_timer (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .tb      (tmr_bus.tmr)
   );

   vov_resp_t resp;
   logic [2:0] retry_code;
   logic [2:0] dly_code;
   vov_tmr_t   dly1_cyc;
   vov_tmr_t   dly2_cyc;

   assign resp       = vov_resp_t'(act_ff[`VOV_RESP_LSB+1:`VOV_RESP_LSB]);
   assign retry_code = act_ff[`VOV_RETRY_LSB+2:`VOV_RETRY_LSB];
   assign dly_code   = act_ff[2:0];

   // codes above 010 have no defined time and fall back to the longest
   always_comb begin
      unique case (dly_code)
         3'h0: dly1_cyc = DLY1_0_CYC;
         3'h1: dly1_cyc = DLY1_1_CYC;
         default: dly1_cyc = DLY1_2_CYC;
      endcase
      unique case (dly_code)
         3'h0: dly2_cyc = DLY2_0_CYC;
         3'h1: dly2_cyc = DLY2_1_CYC;
         default: dly2_cyc = DLY2_2_CYC;
      endcase
   end

   vov_ovs_t   ovs_ff, nxt_ovs;
   logic [2:0] left_ff, nxt_left;
   logic       out_en_ff, nxt_out_en;
   logic [2:0] left_use;
   logic       retry_now;

   // a fresh fault counts from the programmed retry code
   assign left_use = (ovs_ff == VOV_OVS_RUN) ? retry_code : left_ff;

   always_comb begin
      nxt_ovs          = ovs_ff;
      nxt_left         = left_ff;
      retry_now        = 1'b0;
      tmr_bus.load     = 1'b0;
      tmr_bus.load_val = dly1_cyc;
      unique case (ovs_ff)
         VOV_OVS_RUN: begin
            if (ov_det_ff) begin
               unique case (resp)
                  VOV_RESP_NONE: begin
                     nxt_ovs = VOV_OVS_RUN;
                  end
                  VOV_RESP_DELAY: begin
                     nxt_ovs      = VOV_OVS_DLY1;
                     nxt_left     = retry_code;
                     tmr_bus.load = 1'b1;
                  end
                  VOV_RESP_SHUT: begin
                     retry_now = 1'b1;
                  end
                  VOV_RESP_HOLD: begin
                     nxt_ovs = VOV_OVS_HOLD;
                  end
               endcase
            end
         end
         VOV_OVS_DLY1: begin
            if (!ov_det_ff) begin
               nxt_ovs = VOV_OVS_RUN;
            end else if (tmr_bus.done) begin
               retry_now = 1'b1;
            end
         end
         VOV_OVS_OFF: begin
            // output back on for one delay-one window to test the fault
            if (tmr_bus.done) begin
               nxt_ovs      = VOV_OVS_PROBE;
               tmr_bus.load = 1'b1;
            end
         end
         VOV_OVS_PROBE: begin
            if (ov_det_ff) begin
               if (resp == VOV_RESP_DELAY) begin
                  nxt_ovs      = VOV_OVS_DLY1;
                  tmr_bus.load = 1'b1;
               end else if (resp == VOV_RESP_HOLD) begin
                  nxt_ovs = VOV_OVS_HOLD;
               end else if (resp == VOV_RESP_NONE) begin
                  nxt_ovs = VOV_OVS_RUN;
               end else begin
                  retry_now = 1'b1;
               end
            end else if (tmr_bus.done) begin
               nxt_ovs = VOV_OVS_RUN;
            end
         end
         VOV_OVS_HOLD: begin
            if (!ov_det_ff) begin
               nxt_ovs = VOV_OVS_RUN;
            end
         end
         VOV_OVS_LATCH: begin
            nxt_ovs = VOV_OVS_LATCH;
         end
      endcase
      // shared retry decision: spend one attempt or give up for good
      if (retry_now) begin
         if ((retry_code == `VOV_RETRY_INF) || (left_use != 3'h0)) begin
            nxt_ovs          = VOV_OVS_OFF;
            nxt_left         = (retry_code == `VOV_RETRY_INF) ? left_use : left_use - 3'h1;
            tmr_bus.load     = 1'b1;
            tmr_bus.load_val = dly2_cyc;
         end else begin
            nxt_ovs = VOV_OVS_LATCH;
         end
      end
      nxt_out_en = nxt_run && !(nxt_ovs inside {VOV_OVS_OFF, VOV_OVS_HOLD, VOV_OVS_LATCH});
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ovs_ff    <= VOV_OVS_RUN;
         left_ff   <= 3'h0;
         out_en_ff <= 1'b0;
      end else begin
         ovs_ff    <= nxt_ovs;
         left_ff   <= nxt_left;
         out_en_ff <= nxt_out_en;
      end
   end

   assign output_en  = out_en_ff;
   assign ov_latched = (ovs_ff == VOV_OVS_LATCH);
   assign ov_state   = ovs_ff;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence s_fresh_fault(vov_resp_t r);
      (ovs_ff == VOV_OVS_RUN) && ov_det_ff && (resp == r);
   endsequence

   sequence s_retries_gone;
      (ovs_ff == VOV_OVS_DLY1) && ov_det_ff && tmr_bus.done &&
      (retry_code != `VOV_RETRY_INF) && (left_ff == 3'h0);
   endsequence

   setpt_reserved_bits_a: assert property (reg_rd && reg_cmd == `VOV_CMD_SETPOINT |=>
      reg_rvalid && reg_rdata[15:12] == 4'h0 && reg_rdata[11:0] == $past(setpt_ff[11:0]))
      else $error("setpoint read shows reserved bits");
   loop_bit10_a: assert property (reg_rd && reg_cmd == `VOV_CMD_LOOP_SCALE |=>
      reg_rdata[10] == 1'b0)
      else $error("loop scale bit 10 not zero");
   mon_reserved_bits_a: assert property (reg_rd && reg_cmd == `VOV_CMD_MON_SCALE |=>
      reg_rdata[15:14] == 2'h0 && reg_rdata[10] == 1'b0)
      else $error("monitor scale reserved bits not zero");
   vin_mirror_a: assert property (reg_rd && reg_cmd == `VOV_CMD_VIN_STOP |=>
      reg_rdata[15:11] == sext3($past(vin_exp_field)))
      else $error("stop threshold exponent does not mirror input exponent");
   ov_exp_a: assert property (reg_rd && reg_cmd == `VOV_CMD_OV_LIMIT |=>
      reg_rdata[15:11] == sext3($past(mode_exp_ff)))
      else $error("limit exponent does not follow output exponent");
   ro_write_a: assert property (reg_wr && reg_cmd == `VOV_CMD_OV_LIMIT |=>
      ovlim_ff == ($past(reg_wdata) & `VOV_WMASK_MANT11))
      else $error("limit write touched read-only bits");
   start_conv_a: assert property (!run_ff && vin_meas >= start_ff[10:0] |=> run_ff)
      else $error("conversion did not start at threshold");
   stop_conv_a: assert property (run_ff && vin_meas <= stop_ff[10:0] |=> !run_ff)
      else $error("conversion did not stop at threshold");
   ov_detect_a: assert property (vout_meas > ovlim_ff[10:0] |=> ov_fault)
      else $error("overvoltage not flagged");
   resp_none_a: assert property (s_fresh_fault(VOV_RESP_NONE) |=> ovs_ff == VOV_OVS_RUN)
      else $error("response 00 acted on fault");
   delay_run_a: assert property (s_fresh_fault(VOV_RESP_DELAY) ##0 (run_ff && nxt_run) |=>
      ovs_ff == VOV_OVS_DLY1 && output_en)
      else $error("response 01 did not keep running");
   shut_now_a: assert property (s_fresh_fault(VOV_RESP_SHUT) |=> !output_en)
      else $error("response 10 did not shut down at once");
   hold_off_a: assert property (s_fresh_fault(VOV_RESP_HOLD) |=>
      !output_en && ovs_ff == VOV_OVS_HOLD)
      else $error("response 11 did not disable output");
   latch_end_a: assert property (s_retries_gone |=> (ovs_ff == VOV_OVS_LATCH) [*3])
      else $error("spent retries did not latch off");
   latch_off_a: assert property (ovs_ff == VOV_OVS_LATCH |=> !output_en)
      else $error("output on while latched off");
endmodule : vov_regs

// [vov_plant.sv]
module vov_plant (
   input  wire logic        sys_clk,
   input  wire logic        output_en,
   input  wire logic [10:0] vin_set,
   input  wire logic [10:0] vout_set,
   output logic      [10:0] vin_meas,
   output logic      [10:0] vout_meas
);
   timeunit 1ns;
   timeprecision 1ps;
   // stage off lets the output sag to half, so an overvoltage can clear
   initial begin
      vin_meas  = 11'h000;
      vout_meas = 11'h000;
   end
   always @(negedge sys_clk) begin
      vin_meas  <= vin_set;
      vout_meas <= output_en ? vout_set : (vout_set >> 1);
   end
endmodule : vov_plant

// [vov_regs_tb.sv]
module vov_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import vov_pkg::*;
   logic        sys_clk, resetn, reg_wr, reg_rd, reg_rvalid;
   logic [7:0]  reg_cmd;
   logic [15:0] reg_wdata, reg_rdata, loop_scale, monitor_scale_factor;
   logic [2:0]  vin_exp_field, vout_exp;
   logic [10:0] vin_meas, vout_meas, vin_set, vout_set;
   logic [11:0] vout_target_mant;
   logic        conv_run, output_en, ov_fault, ov_latched;
   vov_ovs_t    ov_state;
   int          err_count, n_checks;
   logic [7:0]  cmds [7] = '{8'h21, 8'h29, 8'h2a, 8'h35, 8'h36, 8'h40, 8'h41};
   logic [15:0] masks [7] = '{16'h0fff, 16'hfbff, 16'h3bff, 16'h07ff, 16'h07ff,
                              16'h07ff, 16'h00ff};
   // ------------------------------------------------------------------
   // design, plant and clock
   // ------------------------------------------------------------------
   vov_regs #(.DLY1_0_CYC(28'd20), .DLY1_1_CYC(28'd40), .DLY1_2_CYC(28'd80),
              .DLY2_0_CYC(28'd100), .DLY2_2_CYC(28'd200))
   i_vov_regs (.sys_clk(sys_clk), .resetn(resetn), .reg_cmd(reg_cmd), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .vin_exp_field(vin_exp_field), .vin_meas(vin_meas),
      .vout_meas(vout_meas), .vout_target_mant(vout_target_mant), .vout_exp(vout_exp),
      .loop_scale(loop_scale), .monitor_scale_factor(monitor_scale_factor),
      .conv_run(conv_run), .output_en(output_en), .ov_fault(ov_fault),
      .ov_latched(ov_latched), .ov_state(ov_state));
   vov_plant i_vov_plant (.sys_clk(sys_clk), .output_en(output_en), .vin_set(vin_set),
      .vout_set(vout_set), .vin_meas(vin_meas), .vout_meas(vout_meas));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // ------------------------------------------------------------------
   // access and compare tasks
   // ------------------------------------------------------------------
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h got %h", what, exp, got);
      end
   endtask : chk
   task do_reset;
      resetn = 1'b0;
      repeat (12) @(negedge sys_clk);
      resetn = 1'b1;
   endtask : do_reset
   task wr(input logic [7:0] c, input logic [15:0] d);
      @(negedge sys_clk);
      reg_cmd = c;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask : wr
   // answer lands one cycle after the request, looked at in that cycle
   task rd(input logic [7:0] c, input logic [15:0] e);
      @(negedge sys_clk);
      reg_cmd = c;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      chk("rvalid", 16'h0001, {15'h0, reg_rvalid});
      chk("rdata", e, reg_rdata);
   endtask : rd
   // bounded wait, so a stuck output shows as a mismatch rather than a hang
   task wait_en(input logic v, input int lim);
      int k;
      k = 0;
      while (output_en !== v && k < lim) begin
         @(negedge sys_clk);
         k++;
      end
      chk("output_en", {15'h0, v}, {15'h0, output_en});
   endtask : wait_en
   task conclude;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   initial begin
      #60000;
      err_count++;
      conclude();
   end
   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial begin
      {reg_wr, reg_rd, reg_cmd, reg_wdata, vin_exp_field} = '0;
      vin_set = 11'd0;
      vout_set = 11'd0;
      do_reset();
      for (int i = 0; i < 7; i++) begin
         rd(cmds[i], 16'h0000);
         wr(cmds[i], 16'hffff);
         rd(cmds[i], masks[i]);
      end
      chk("target", 16'h0fff, {4'h0, vout_target_mant});
      chk("loop", 16'hfbff, loop_scale);
      chk("monitor", 16'h3bff, monitor_scale_factor);
      wr(8'h22, 16'hffff);
      rd(8'h22, 16'h0000);
      vin_exp_field = 3'h5;
      rd(8'h35, 16'hefff);
      rd(8'h36, 16'hefff);
      wr(8'h20, 16'hfffe);
      rd(8'h20, 16'h0006);
      chk("vout_exp", 16'h0006, {13'h0, vout_exp});
      rd(8'h40, 16'hf7ff);
      // hysteresis between the start and stop thresholds
      wr(8'h35, 16'd100);
      wr(8'h36, 16'd50);
      vin_set = 11'd80;
      repeat (4) @(negedge sys_clk);
      chk("run", 16'h0000, {15'h0, conv_run});
      vin_set = 11'd100;
      repeat (4) @(negedge sys_clk);
      chk("run", 16'h0001, {15'h0, conv_run});
      vin_set = 11'd51;
      repeat (4) @(negedge sys_clk);
      chk("run", 16'h0001, {15'h0, conv_run});
      vin_set = 11'd50;
      repeat (4) @(negedge sys_clk);
      chk("run", 16'h0000, {15'h0, conv_run});
      vin_set = 11'd100;
      wr(8'h40, 16'd200);
      wr(8'h41, 16'h0000);
      vout_set = 11'd300;
      repeat (6) @(negedge sys_clk);
      chk("fault", 16'h0001, {15'h0, ov_fault});
      chk("en", 16'h0001, {15'h0, output_en});
      // code 01, delay one of 40 cycles, no retries
      wr(8'h41, 16'h0041);
      repeat (30) @(negedge sys_clk);
      chk("en", 16'h0001, {15'h0, output_en});
      chk("state", {13'h0, VOV_OVS_DLY1}, {13'h0, ov_state});
      wait_en(1'b0, 20);
      vout_set = 11'd0;
      repeat (6) @(negedge sys_clk);
      chk("latch", 16'h0001, {15'h0, ov_latched});
      // code 10 with one retry after delay two of 100 cycles
      do_reset();
      wr(8'h40, 16'd200);
      wr(8'h41, 16'h0088);
      vout_set = 11'd300;
      wait_en(1'b0, 6);
      wait_en(1'b1, 120);
      wait_en(1'b0, 10);
      chk("latch", 16'h0001, {15'h0, ov_latched});
      // code 11 drops the output until the sag clears the fault
      do_reset();
      wr(8'h40, 16'd200);
      wr(8'h41, 16'h00c0);
      wait_en(1'b0, 6);
      chk("state", {13'h0, VOV_OVS_HOLD}, {13'h0, ov_state});
      wait_en(1'b1, 10);
      wr(8'h41, 16'h00b8);
      repeat (400) @(negedge sys_clk);
      chk("latch", 16'h0000, {15'h0, ov_latched});
      conclude();
   end
endmodule : vov_regs_tb
